// ### pkg/npr_pkg.sv
// Constants, states and the state record of the NAND pointer and page read host.
// Assumes a 200 MHz host clock and a byte-wide NAND part on asynchronous strobes.
package npr_pkg;

  // ****************************************
  // Clock and pin timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 5;
  localparam int T_WP_NS = 35;   // Wide enough to cover the short chip-enable set-up case
  localparam int T_WC_NS = 50;
  localparam int T_REA_NS = 35;
  localparam int T_REH_NS = 15;
  localparam int T_WB_NS = 100;
  localparam int T_RR_NS = 20;
  localparam int T_WHR_NS = 60;
  localparam int T_ADL_NS = 100;
  localparam int T_CEH_NS = 100;

  localparam logic [7:0] WP_CYC = 8'((T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] WH_CYC = 8'((T_WC_NS - T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] RL_CYC = 8'(T_REA_NS / CLK_PERIOD_NS + 1);  // Sample strictly after access time
  localparam logic [7:0] RH_CYC = 8'((T_REH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] WB_CYC = 8'((T_WB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] RR_CYC = 8'((T_RR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] WHR_CYC = 8'((T_WHR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] ADL_CYC = 8'((T_ADL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] CEH_CYC = 8'(T_CEH_NS / CLK_PERIOD_NS + 1);  // Must exceed the hold time

  // ****************************************
  // Commands, areas, operations
  // ****************************************
  localparam logic [7:0] CMD_PTR_A = 8'h00;
  localparam logic [7:0] CMD_PTR_B = 8'h01;
  localparam logic [7:0] CMD_PTR_C = 8'h50;
  localparam logic [7:0] CMD_LOAD = 8'h80;
  localparam logic [7:0] CMD_CONFIRM = 8'h10;
  localparam logic [7:0] CMD_ERASE = 8'h60;
  localparam logic [7:0] CMD_ERASE_GO = 8'hD0;
  localparam logic [7:0] CMD_STATUS = 8'h70;

  localparam logic [1:0] AREA_A = 2'h0;
  localparam logic [1:0] AREA_B = 2'h1;
  localparam logic [1:0] AREA_C = 2'h2;
  localparam logic [1:0] OP_READ = 2'h0;
  localparam logic [1:0] OP_PROG = 2'h1;
  localparam logic [1:0] OP_ERASE = 2'h2;

  // ****************************************
  // Page geometry
  // ****************************************
  localparam logic [9:0] HALF_BASE = 10'h100;
  localparam logic [9:0] SPARE_BASE = 10'h200;
  localparam logic [9:0] PAGE_LAST = 10'h20F;
  localparam logic [4:0] BLOCK_LAST_PAGE = 5'h1F;
  localparam int BLOCKS = 2048;
  localparam int BLOCK_AW = 11;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0, ST_LOOKUP = 4'h1, ST_CMD = 4'h2, ST_ADDR = 4'h3, ST_GAP = 4'h4, ST_WDATA = 4'h5,
    ST_WAITB = 4'h6, ST_WAITR = 4'h7, ST_RDATA = 4'h8, ST_STAT = 4'h9, ST_CEH = 4'hA
  } npr_state_t;

  typedef struct packed {
    npr_state_t st;
    logic ph;
    logic [7:0] tmr;
    logic [1:0] cstep;
    logic [1:0] idx;
    logic [1:0] op;
    logic [1:0] area;
    logic [7:0] scol;
    logic [9:0] col;
    logic [15:0] page;
    logic [15:0] cnt;
    logic restart;
    logic ce_n;
    logic cle;
    logic ale;
    logic we_n;
    logic re_n;
    logic oe;
    logic [7:0] io;
    logic [7:0] rdata;
    logic rvalid;
    logic wready;
    logic op_ready;
    logic done;
    logic fail;
    logic refused;
    logic mark;
  } npr_regs_t;

endpackage

// ### rtl/npr_bad_table.sv
// One flag per erase block, set when a program or erase of that block fails.
// Assumes one access per cycle; read data is registered and valid one cycle after the address.
module npr_bad_table #(
  parameter int DEPTH = npr_pkg::BLOCKS,
  parameter int AW = npr_pkg::BLOCK_AW
) (
  input wire logic clk_in,          // Host clock
  input wire logic rst_n_in,        // Asynchronous reset, active low
  input wire logic [AW-1:0] addr_in, // Block index
  input wire logic mark_in,         // Set the flag of addr_in
  output logic bad_out              // Registered flag of addr_in
);

  logic [DEPTH-1:0] bits;

  // Flags clear at reset; a write and a read of one block in one cycle return the old value
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bits <= '0;
      bad_out <= 1'b0;
    end else begin
      if (mark_in) begin
        bits[addr_in] <= 1'b1;
      end
      bad_out <= bits[addr_in];
    end
  end

endmodule

// ### rtl/npr_host.sv
// Host sequencer for a byte-wide NAND part: page read, sequential row read, program, erase.
// Assumes the pins are sampled synchronously and the ready/busy pin reads high when ready.
// Summary of operation
// - Matching pointer command precedes every data load
// - Second-half pointer written directly before load command
// - Read is pointer command plus three address bytes
// - Main-area pointer restored after spare reads; here each read and load writes its own pointer instead
// - Chip enable high ends a sequential read
// - Sequential reads stop and restart at block ends
// - Failed program reported so caller can relocate
// - Failed blocks recorded and never erased again
// - Confirm sent only after data was loaded
module npr_host (
  input wire logic CLK_IN,              // 200 MHz clock
  input wire logic RST_N_IN,            // Asynchronous reset, active low
  input wire logic OP_VALID_IN,         // Operation request
  input wire logic [1:0] OP_IN,         // Read, program or erase
  input wire logic [1:0] AREA_IN,       // Start area
  input wire logic [7:0] COL_IN,        // Column inside the area
  input wire logic [15:0] PAGE_IN,      // Row address
  input wire logic [15:0] COUNT_IN,     // Bytes to read or load
  output logic OP_READY_OUT,            // Idle, request taken
  input wire logic [7:0] WDATA_IN,      // Program data
  input wire logic WVALID_IN,           // Program data valid
  output logic WREADY_OUT,              // Program data taken
  output logic [7:0] RDATA_OUT,         // Read data
  output logic RVALID_OUT,              // Read data strobe
  output logic DONE_OUT,                // Operation finished
  output logic FAIL_OUT,                // Status reported failure
  output logic REFUSED_OUT,             // Erase of a bad block refused
  output logic NAND_CE_N_OUT,           // Chip enable, active low
  output logic NAND_CLE_OUT,            // Command latch enable
  output logic NAND_ALE_OUT,            // Address latch enable
  output logic NAND_WE_N_OUT,           // Write strobe, active low
  output logic NAND_RE_N_OUT,           // Read strobe, active low
  output logic [7:0] NAND_IO_OUT,       // Data bus out
  output logic NAND_IO_OE_OUT,          // Data bus drive enable
  input wire logic [7:0] NAND_IO_IN,    // Data bus in
  input wire logic NAND_RB_IN           // Ready high, busy low
);

  npr_pkg::npr_regs_t s;
  npr_pkg::npr_regs_t next_s;
  logic kick;
  logic [7:0] kb;
  logic kc;
  logic ka;
  logic tbl_bad;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [7:0] ptr_code(input logic [1:0] area);
    unique case (area)
      npr_pkg::AREA_B: ptr_code = npr_pkg::CMD_PTR_B;
      npr_pkg::AREA_C: ptr_code = npr_pkg::CMD_PTR_C;
      default: ptr_code = npr_pkg::CMD_PTR_A;
    endcase
  endfunction

  function automatic logic [9:0] col_start(input logic [1:0] area, input logic [7:0] scol);
    unique case (area)
      npr_pkg::AREA_B: col_start = npr_pkg::HALF_BASE + {2'h0, scol};
      npr_pkg::AREA_C: col_start = npr_pkg::SPARE_BASE + {6'h00, scol[3:0]};
      default: col_start = {2'h0, scol};
    endcase
  endfunction

  function automatic logic [7:0] addr_byte(input logic [1:0] i, input logic [1:0] area, input logic [7:0] scol,
                                           input logic [15:0] page);
    unique case (i)
      2'h0: addr_byte = (area == npr_pkg::AREA_C) ? {4'h0, scol[3:0]} : scol;
      2'h1: addr_byte = page[7:0];
      default: addr_byte = page[15:8];
    endcase
  endfunction

  // Bad block flags, addressed by the block of the current page
  npr_bad_table u_table (
    .clk_in(CLK_IN),
    .rst_n_in(RST_N_IN),
    .addr_in(s.page[15:5]),
    .mark_in(s.mark),
    .bad_out(tbl_bad)
  );

  // ****************************************
  // Sequencer
  // ****************************************
  // Every bus cycle is a low phase then a high phase; kick starts the next write cycle
  always_comb begin
    next_s = s;
    kick = 1'b0;
    kb = 8'h00;
    kc = 1'b0;
    ka = 1'b0;
    next_s.rvalid = 1'b0;
    next_s.done = 1'b0;
    next_s.mark = 1'b0;
    unique case (s.st)
      npr_pkg::ST_IDLE: begin
        next_s.op_ready = 1'b1;
        if (OP_VALID_IN && s.op_ready) begin
          next_s.op_ready = 1'b0;
          next_s.op = OP_IN;
          next_s.area = AREA_IN;
          next_s.scol = COL_IN;
          next_s.col = col_start(AREA_IN, COL_IN);
          next_s.page = PAGE_IN;
          next_s.cnt = COUNT_IN;
          next_s.fail = 1'b0;
          next_s.refused = 1'b0;
          next_s.restart = 1'b0;
          next_s.ce_n = 1'b0;
          if (OP_IN == npr_pkg::OP_ERASE) begin
            next_s.st = npr_pkg::ST_LOOKUP;
            next_s.ph = 1'b0;
          end else begin
            // Every read and load opens with its own pointer, so no stale one survives
            next_s.st = npr_pkg::ST_CMD;
            next_s.cstep = 2'h0;
            kick = 1'b1;
            kb = ptr_code(AREA_IN);
            kc = 1'b1;
          end
        end
      end
      npr_pkg::ST_LOOKUP: begin
        if (!s.ph) begin
          next_s.ph = 1'b1;
        end else if (tbl_bad) begin
          next_s.refused = 1'b1;
          next_s.done = 1'b1;
          next_s.ce_n = 1'b1;
          next_s.st = npr_pkg::ST_IDLE;
        end else begin
          next_s.st = npr_pkg::ST_CMD;
          next_s.cstep = 2'h1;
          kick = 1'b1;
          kb = npr_pkg::CMD_ERASE;
          kc = 1'b1;
        end
      end
      npr_pkg::ST_CMD, npr_pkg::ST_ADDR, npr_pkg::ST_WDATA: begin
        if (s.tmr != 8'h00) begin
          next_s.tmr = s.tmr - 8'h01;
        end else if (!s.ph) begin
          next_s.ph = 1'b1;
          next_s.we_n = 1'b1;
          next_s.tmr = npr_pkg::WH_CYC - 8'h01;
        end else if (s.st == npr_pkg::ST_WDATA && s.wready) begin
          // Loader stalls here until the caller offers a byte
          if (WVALID_IN) begin
            next_s.wready = 1'b0;
            kick = 1'b1;
            kb = WDATA_IN;
          end
        end else begin
          next_s.cle = 1'b0;
          next_s.ale = 1'b0;
          next_s.oe = 1'b0;
          if (s.st == npr_pkg::ST_CMD) begin
            unique case (s.cstep)
              2'h0: begin
                if (s.op == npr_pkg::OP_PROG) begin
                  next_s.cstep = 2'h1;
                  kick = 1'b1;
                  kb = npr_pkg::CMD_LOAD;
                  kc = 1'b1;
                end else begin
                  next_s.st = npr_pkg::ST_ADDR;
                  next_s.idx = 2'h0;
                  kick = 1'b1;
                  kb = addr_byte(2'h0, s.area, s.scol, s.page);
                  ka = 1'b1;
                end
              end
              2'h1: begin
                next_s.st = npr_pkg::ST_ADDR;
                next_s.idx = (s.op == npr_pkg::OP_ERASE) ? 2'h1 : 2'h0;
                kick = 1'b1;
                kb = addr_byte(next_s.idx, s.area, s.scol, s.page);
                ka = 1'b1;
              end
              2'h2: begin
                next_s.st = npr_pkg::ST_WAITB;
                next_s.tmr = npr_pkg::WB_CYC - 8'h01;
              end
              default: begin
                next_s.st = npr_pkg::ST_GAP;
                next_s.tmr = npr_pkg::WHR_CYC - 8'h01;
              end
            endcase
          end else if (s.st == npr_pkg::ST_ADDR) begin
            if (s.idx != 2'h2) begin
              next_s.idx = s.idx + 2'h1;
              kick = 1'b1;
              kb = addr_byte(s.idx + 2'h1, s.area, s.scol, s.page);
              ka = 1'b1;
            end else if (s.op == npr_pkg::OP_READ) begin
              next_s.st = npr_pkg::ST_WAITB;
              next_s.tmr = npr_pkg::WB_CYC - 8'h01;
            end else if (s.op == npr_pkg::OP_ERASE) begin
              next_s.cstep = 2'h2;
              next_s.st = npr_pkg::ST_CMD;
              kick = 1'b1;
              kb = npr_pkg::CMD_ERASE_GO;
              kc = 1'b1;
            end else if (s.cnt == 16'h0000) begin
              // Nothing loaded: no confirm, so the part never starts programming
              next_s.st = npr_pkg::ST_CEH;
              next_s.ce_n = 1'b1;
              next_s.tmr = npr_pkg::CEH_CYC - 8'h01;
            end else begin
              next_s.st = npr_pkg::ST_GAP;
              next_s.cstep = 2'h1;
              next_s.tmr = npr_pkg::ADL_CYC - 8'h01;
            end
          end else begin
            next_s.cnt = s.cnt - 16'h0001;
            if (s.cnt == 16'h0001) begin
              next_s.st = npr_pkg::ST_CMD;
              next_s.cstep = 2'h2;
              kick = 1'b1;
              kb = npr_pkg::CMD_CONFIRM;
              kc = 1'b1;
            end else begin
              next_s.wready = 1'b1;
            end
          end
        end
      end
      npr_pkg::ST_GAP: begin
        if (s.tmr != 8'h00) begin
          next_s.tmr = s.tmr - 8'h01;
        end else if (s.cstep == 2'h3) begin
          next_s.st = npr_pkg::ST_STAT;
          next_s.ph = 1'b0;
          next_s.re_n = 1'b0;
          next_s.tmr = npr_pkg::RL_CYC - 8'h01;
        end else begin
          next_s.st = npr_pkg::ST_WDATA;
          next_s.ph = 1'b1;
          next_s.wready = 1'b1;
        end
      end
      npr_pkg::ST_WAITB: begin
        if (s.tmr != 8'h00) begin
          next_s.tmr = s.tmr - 8'h01;
        end else begin
          next_s.st = npr_pkg::ST_WAITR;
          next_s.ph = 1'b0;
        end
      end
      npr_pkg::ST_WAITR: begin
        if (!s.ph) begin
          if (NAND_RB_IN) begin
            next_s.ph = 1'b1;
            next_s.tmr = npr_pkg::RR_CYC - 8'h01;
          end
        end else if (s.tmr != 8'h00) begin
          next_s.tmr = s.tmr - 8'h01;
        end else if (s.op == npr_pkg::OP_READ) begin
          next_s.st = npr_pkg::ST_RDATA;
          next_s.ph = 1'b0;
          next_s.re_n = 1'b0;
          next_s.tmr = npr_pkg::RL_CYC - 8'h01;
        end else begin
          next_s.st = npr_pkg::ST_CMD;
          next_s.cstep = 2'h3;
          kick = 1'b1;
          kb = npr_pkg::CMD_STATUS;
          kc = 1'b1;
        end
      end
      npr_pkg::ST_RDATA, npr_pkg::ST_STAT: begin
        if (s.tmr != 8'h00) begin
          next_s.tmr = s.tmr - 8'h01;
        end else if (!s.ph) begin
          next_s.ph = 1'b1;
          next_s.re_n = 1'b1;
          next_s.tmr = npr_pkg::RH_CYC - 8'h01;
          if (s.st == npr_pkg::ST_RDATA) begin
            next_s.rdata = NAND_IO_IN;
            next_s.rvalid = 1'b1;
          end else begin
            next_s.fail = NAND_IO_IN[0];
            next_s.mark = NAND_IO_IN[0];
          end
        end else if (s.st == npr_pkg::ST_STAT || s.cnt == 16'h0001) begin
          next_s.cnt = s.cnt - 16'h0001;
          next_s.st = npr_pkg::ST_CEH;
          next_s.ce_n = 1'b1;
          next_s.tmr = npr_pkg::CEH_CYC - 8'h01;
        end else begin
          next_s.cnt = s.cnt - 16'h0001;
          next_s.col = s.col + 10'h001;
          next_s.ph = 1'b0;
          next_s.re_n = 1'b0;
          next_s.tmr = npr_pkg::RL_CYC - 8'h01;
          if (s.col == npr_pkg::PAGE_LAST) begin
            next_s.page = s.page + 16'h0001;
            next_s.col = (s.area == npr_pkg::AREA_C) ? npr_pkg::SPARE_BASE : 10'h000;
            next_s.re_n = 1'b1;
            if (s.page[4:0] == npr_pkg::BLOCK_LAST_PAGE) begin
              // Part may not run across a block: close the burst and readdress
              next_s.restart = 1'b1;
              next_s.scol = 8'h00;
              next_s.area = (s.area == npr_pkg::AREA_B) ? npr_pkg::AREA_A : s.area;
              next_s.st = npr_pkg::ST_CEH;
              next_s.ce_n = 1'b1;
              next_s.tmr = npr_pkg::CEH_CYC - 8'h01;
            end else begin
              next_s.st = npr_pkg::ST_WAITB;
              next_s.tmr = npr_pkg::WB_CYC - 8'h01;
            end
          end
        end
      end
      npr_pkg::ST_CEH: begin
        if (s.tmr != 8'h00) begin
          next_s.tmr = s.tmr - 8'h01;
        end else if (s.restart) begin
          next_s.restart = 1'b0;
          next_s.ce_n = 1'b0;
          next_s.st = npr_pkg::ST_CMD;
          next_s.cstep = 2'h0;
          kick = 1'b1;
          kb = ptr_code(s.area);
          kc = 1'b1;
        end else begin
          next_s.done = 1'b1;
          next_s.st = npr_pkg::ST_IDLE;
        end
      end
      default: begin
        next_s.st = npr_pkg::ST_IDLE;
      end
    endcase
    if (kick) begin
      next_s.we_n = 1'b0;
      next_s.io = kb;
      next_s.cle = kc;
      next_s.ale = ka;
      next_s.oe = 1'b1;
      next_s.ph = 1'b0;
      next_s.tmr = npr_pkg::WP_CYC - 8'h01;
    end
  end

  // State register; chip enable and strobes idle high, latches low and bus released at reset
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      s <= '0;
      s.st <= npr_pkg::ST_IDLE;
      s.ce_n <= 1'b1;
      s.we_n <= 1'b1;
      s.re_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from the state register
  assign OP_READY_OUT = s.op_ready;
  assign WREADY_OUT = s.wready;
  assign RDATA_OUT = s.rdata;
  assign RVALID_OUT = s.rvalid;
  assign DONE_OUT = s.done;
  assign FAIL_OUT = s.fail;
  assign REFUSED_OUT = s.refused;
  assign NAND_CE_N_OUT = s.ce_n;
  assign NAND_CLE_OUT = s.cle;
  assign NAND_ALE_OUT = s.ale;
  assign NAND_WE_N_OUT = s.we_n;
  assign NAND_RE_N_OUT = s.re_n;
  assign NAND_IO_OUT = s.io;
  assign NAND_IO_OE_OUT = s.oe;

  // ****************************************
  // Checks
  // ****************************************
  logic h_we;
  logic [7:0] h_last_cmd;
  logic [1:0] h_acnt;
  logic h_data;
  logic [4:0] h_ceh;
  logic we_rise;
  assign we_rise = s.we_n && !h_we;

  // Bus history seen by the part: last command, address bytes since it and data since the last load command
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      h_we <= 1'b1;
      h_last_cmd <= 8'h00;
      h_acnt <= 2'h0;
      h_data <= 1'b0;
      h_ceh <= 5'h00;
    end else begin
      h_we <= s.we_n;
      h_ceh <= !s.ce_n ? 5'h00 : (h_ceh == 5'h1F ? h_ceh : h_ceh + 5'h01);
      if (we_rise && s.cle) begin
        h_last_cmd <= s.io;
        h_acnt <= 2'h0;
        if (s.io == npr_pkg::CMD_LOAD) begin
          h_data <= 1'b0;
        end
      end else if (we_rise && s.ale) begin
        h_acnt <= (h_acnt == 2'h3) ? h_acnt : h_acnt + 2'h1;
      end else if (we_rise) begin
        h_data <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);

  a_ptr_before_load: assert property (we_rise && s.cle && s.io == npr_pkg::CMD_LOAD |-> h_acnt == 2'h0 &&
    (h_last_cmd == npr_pkg::CMD_PTR_A || h_last_cmd == npr_pkg::CMD_PTR_B || h_last_cmd == npr_pkg::CMD_PTR_C))
    else $error("load command not directly after a pointer");
  a_ptr_area: assert property (we_rise && s.cle && s.st == npr_pkg::ST_CMD && s.cstep == 2'h0 |->
    s.io == ptr_code(s.area)) else $error("pointer code does not match area");
  a_read_addr: assert property (s.st == npr_pkg::ST_WAITB && $past(s.st) == npr_pkg::ST_ADDR
    && s.op == npr_pkg::OP_READ |-> h_acnt == 2'h3) else $error("read without three address bytes");
  // Erase ignores the area, so its first address byte is a page byte and is not checked here
  a_spare_col: assert property (we_rise && s.ale && h_acnt == 2'h0 && s.area == npr_pkg::AREA_C
    && s.op != npr_pkg::OP_ERASE
    |-> s.io[7:4] == 4'h0) else $error("spare column uses upper bits");
  a_confirm_data: assert property (we_rise && s.cle && s.io == npr_pkg::CMD_CONFIRM |-> h_data)
    else $error("confirm without loaded data");
  a_ceh_end: assert property ($rose(s.done) && s.op == npr_pkg::OP_READ |-> s.ce_n && h_ceh >= 5'h15)
    else $error("read ended without chip enable hold");
  a_block_stay: assert property (s.st == npr_pkg::ST_WAITB && $past(s.st) == npr_pkg::ST_RDATA |->
    s.page[4:0] != 5'h00 && s.page == $past(s.page) + 16'h0001) else $error("page advance crossed block");
  a_re_low: assert property ($fell(s.re_n) |-> !s.re_n [*8])
    else $error("read strobe low too short");
  a_ready_first: assert property ($fell(s.re_n) && $past(s.st) == npr_pkg::ST_WAITR |-> $past(NAND_RB_IN, 5))
    else $error("read began without ready");
  a_bad_refused: assert property (s.st == npr_pkg::ST_LOOKUP && s.ph && tbl_bad |=>
    s.refused && s.done && s.st == npr_pkg::ST_IDLE ##1 s.op_ready) else $error("bad block not refused");

  c_read_done: cover property (s.done && s.op == npr_pkg::OP_READ);
  c_prog_fail: cover property (s.done && s.op == npr_pkg::OP_PROG && s.fail);
  c_page_step: cover property (s.st == npr_pkg::ST_WAITB && $past(s.st) == npr_pkg::ST_RDATA);
  c_refused: cover property (s.refused && s.done);

endmodule

// ### dv/npr_nand_model.sv
// Behavioural NAND part facing the host sequencer.
// Assumes clean strobes from a clocked host; delays are in ns.
module npr_nand_model #(parameter int TR_NS = 200) (
  input wire logic ce_n_in,     // Chip enable, active low
  input wire logic cle_in,      // Command latch
  input wire logic ale_in,      // Address latch
  input wire logic we_n_in,     // Write strobe, active low
  input wire logic re_n_in,     // Read strobe, active low
  input wire logic [7:0] io_in, // Resolved bus level
  output logic [7:0] io_out,    // Part drive
  output logic rb_out           // High when ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] area = 2'h0;
  logic [1:0] na = 2'h0;
  logic [9:0] col = 10'h000;
  logic [15:0] page = 16'h0000;
  logic stat = 1'b0, prog = 1'b0, loaded = 1'b0, sp = 1'b0, ef = 1'b0;
  initial rb_out = 1'b1;
  initial io_out = 8'h00;
  // ********
  // Latching
  // ********
  // Busy is a level with a scheduled end, so the strobes keep being watched
  task automatic busy;
    rb_out = 1'b0;
    rb_out <= #(TR_NS) 1'b1;
  endtask
  // State survives chip enable going high, only strobes are ignored then
  always @(posedge we_n_in) if (!ce_n_in) begin
    if (cle_in) begin
      na = 2'h0;
      stat = io_in == 8'h70;
      if (io_in == 8'h00 || io_in == 8'h01 || io_in == 8'h50) area = {io_in[6], io_in[0]};
      if (io_in == 8'h10 && loaded) busy();
      // Every erase reports failure so the host's bad-block path gets exercised
      if (io_in == 8'h60 || io_in == 8'h80) ef = io_in == 8'h60;
      if (io_in == 8'hD0) busy();
      prog = io_in == 8'h80;
      loaded = 1'b0;
    end else if (ale_in) begin
      if (na == 2'h0) col = area == 2'h2 ? 10'h200 + 10'(io_in[3:0]) : {area, io_in};
      if (na == 2'h1) page[7:0] = io_in;
      if (na == 2'h2) begin
        page[15:8] = io_in;
        sp = col[9];
        if (area == 2'h1) area = 2'h0;
        if (!prog) busy();
      end
      na = na + 2'h1;
    end else if (prog) loaded = 1'b1;
  end
  // One byte per falling read strobe; page end steps to the next page
  always @(negedge re_n_in) if (!ce_n_in) begin
    io_out = stat ? {7'h60, ef} : 8'(col * 3 + page);
    if (!stat && col == 10'h20F) begin
      col = sp ? 10'h200 : 10'h000;
      page++;
      busy();
    end else if (!stat) col++;
  end
  // Released bus shows the inverse so a late sample cannot pass
  always @(posedge re_n_in) io_out <= #10 ~io_out;
endmodule

// ### dv/testbench.sv
// Self-checking bench for the NAND host sequencer.
// Assumes the package, the design and the part model are compiled first.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_n = 1'b0, ov = 1'b0;
  logic [1:0] op = 2'h0, ar = 2'h0;
  logic [7:0] cl = 8'h00, io_o, io_m, rd;
  logic [15:0] pg = 16'h0000, cnt = 16'h0001;
  logic rdy, rv, done, fl, ce, cle, ale, we, re, oe, rb, wr, rf;
  int fails = 0, n_checks = 0;
  `define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin fails++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
  npr_host uut (.CLK_IN(clk), .RST_N_IN(rst_n), .OP_VALID_IN(ov), .OP_IN(op), .AREA_IN(ar), .COL_IN(cl),
    .PAGE_IN(pg), .COUNT_IN(cnt), .OP_READY_OUT(rdy), .WDATA_IN(8'h5A), .WVALID_IN(1'b1), .WREADY_OUT(wr),
    .RDATA_OUT(rd), .RVALID_OUT(rv), .DONE_OUT(done), .FAIL_OUT(fl), .REFUSED_OUT(rf), .NAND_CE_N_OUT(ce),
    .NAND_CLE_OUT(cle), .NAND_ALE_OUT(ale), .NAND_WE_N_OUT(we), .NAND_RE_N_OUT(re), .NAND_IO_OUT(io_o),
    .NAND_IO_OE_OUT(oe), .NAND_IO_IN(oe ? io_o : io_m), .NAND_RB_IN(rb));
  npr_nand_model part (.ce_n_in(ce), .cle_in(cle), .ale_in(ale), .we_n_in(we), .re_n_in(re),
    .io_in(oe ? io_o : io_m), .io_out(io_m), .rb_out(rb));
  initial forever #2.5 clk = ~clk;
  // ********
  // Scenarios
  // ********
  // Issue one operation and follow the expected column and page per byte
  task automatic run(input logic [1:0] o, a, input logic [7:0] c, input logic [15:0] p, n);
    logic [9:0] k;
    logic [15:0] q;
    logic [15:0] nb;
    k = a == 2'h2 ? 10'h200 + 10'(c[3:0]) : {a, c};
    q = p;
    nb = 16'h0000;
    @(negedge clk);
    {ov, op, ar, cl, pg, cnt} = {1'b1, o, a, c, p, n};
    while (rdy !== 1'b1) @(negedge clk);
    @(negedge clk);
    ov = 1'b0;
    for (int i = 0; i < 9000 && done !== 1'b1; i++) begin
      @(negedge clk);
      // Load data is always offered, so each ready cycle takes exactly one byte
      if (wr === 1'b1) nb++;
      if (rv === 1'b1) begin
        `CHK(rd, 8'(k * 3 + q))
        nb++;
        if (k == 10'h20F) begin
          k = a == 2'h2 ? 10'h200 : 10'h000;
          q++;
        end else k++;
      end
    end
    `CHK(done, 1'b1)
    if (o != 2'h2) `CHK(nb, n)
  endtask
  // Crosses from the first half into the second on one page
  task automatic t_main;
    run(2'h0, 2'h0, 8'hFD, 16'h0003, 16'h0005);
    $display("test main done");
  endtask
  // Second half runs on into the spare bytes
  task automatic t_half;
    run(2'h0, 2'h1, 8'hFE, 16'h0004, 16'h0003);
    $display("test half done");
  endtask
  // Upper column bits are dropped and the page end wraps to the next spare
  task automatic t_spare;
    run(2'h0, 2'h2, 8'hFE, 16'h0005, 16'h0004);
    $display("test spare done");
  endtask
  // Load two bytes from the second half and read back a passing status
  task automatic t_prog;
    run(2'h1, 2'h1, 8'h00, 16'h0007, 16'h0002);
    `CHK(fl, 1'b0)
    run(2'h0, 2'h0, 8'h00, 16'h0007, 16'h0001);
    $display("test program done");
  endtask
  // A failed erase marks its block; a second erase of that block is refused
  task automatic t_erase;
    run(2'h2, 2'h0, 8'h00, 16'h0040, 16'h0001);
    `CHK({fl, rf}, 2'b10)
    run(2'h2, 2'h0, 8'h00, 16'h0045, 16'h0001);
    `CHK({fl, rf}, 2'b01)
    $display("test erase done");
  endtask
  task automatic results;
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Whole sequence needs well under a tenth of this span
  initial begin
    #200us;
    fails++;
    results();
  end
  initial begin
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    t_main();
    t_half();
    t_spare();
    t_prog();
    t_erase();
    results();
  end
endmodule
